// ===== common/addr_decode_defs.vh
// constants for the internal address decode and scratch pad select block
`ifndef ADDR_DECODE_DEFS_VH
`define ADDR_DECODE_DEFS_VH
// internal processor bus addresses
`define STATUS_WORD_ADDR  16'hfffe
`define STACK_LIMIT_ADDR  16'hfffc
`define SWITCH_WORD_ADDR  16'hff78
`define SCRATCH_BASE_HI   12'hffc
// register port offsets
`define REG_CTRL          8'h00
`define REG_LIMIT         8'h04
`define REG_STATUS        8'h08
// control field positions and reset value
`define CTRL_LIMIT_FITTED 0
`define CTRL_HALT_ENABLE  1
`define CTRL_RESET        2'h0
`define LIMIT_RESET       8'h00
// red zone lies this many bytes below the yellow boundary
`define RED_ZONE_BYTES    16'h0020
// special scratch pad register numbers
`define STACK_PTR_REG     4'h6
`endif

// ===== core/addr_decode_core.v
// internal address decode, scratch pad select and microaddress match
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
// Overview of operation
// [RULE1] status word address hit enables status load and starts a slave sync
// [RULE2] status word hit also requests a re-service of pending bus requests
// [RULE3] stack limit hit stays off unless option fitted; then selects and syncs
// [RULE4] decode scratch pad bus addresses for console examine and deposit
// [RULE5] switch word address, like the status word, scratch pad and fitted stack limit addresses, starts a slave sync
// [RULE6] test output true when bus address bits 06:03 are all zero
// [RULE7] active low output when bus address bits 07:05 are all ones
// [RULE8] active low test output when bus address bits 15:08 are all ones
// [RULE9] red zone stack violation raises a stop that breaks microflow
// [RULE10] yellow zone violation gives active low trap flag, no stop
// [RULE11] detect result bits 15:00 zero for zero code and microbranch
// [RULE12] detect result bits 03:00 zero as part of byte zero over 07:00
// [RULE13] scratch address from exactly one of four sources
// [RULE14] scratch pad written from datapath bus, read onto wired-OR bus
// [RULE15] detect registers 6,7,16,17 octal; byte ops on 6/7 step by 2
// [RULE16] register 06 selected enables stack overflow check
// [RULE17] applied select lines are the complement of the register number
// [RULE18] switch gate drives console switches onto bus data 15:00
// [RULE19] level true when switch bits 08:00 equal next microaddress
// [RULE20] cycle end pulse gated with match gives active low trigger pulse
// [RULE21] halt on match only after a long clock class microword; code tests the word two before the target, latched at the previous cycle end
// [RULE22] switch bits 17:16 passed to memory management extension
// [RULE23] compared microaddress is the branched next address, jam only alters
`include "addr_decode_defs.vh"

module addr_decode_core #(
  parameter REG_COUNT = 16,
  parameter DATA_W    = 16
) (
  // clock and reset
  input  wire              i_mclk,
  input  wire              i_rst_n,
  // register port
  input  wire [7:0]        i_addr,
  input  wire [31:0]       i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [31:0]       o_rdata,
  // bus address and access
  input  wire [15:0]       i_bus_addr,
  input  wire              i_bus_access,
  input  wire              i_stack_access,
  output reg               o_status_word_addr_hit,
  output reg               o_status_load_en,
  output reg               o_rebranch_req,
  output reg               o_stack_limit_addr_hit,
  output reg               o_scratch_addr_hit,
  output reg               o_switch_word_addr_hit,
  output reg               o_slave_sync_ack,
  output reg               o_ba_mid_zero,
  output reg               o_ba_upper_ones_n,
  output reg               o_ba_high_ones_n,
  // stack zone checks
  output reg               o_stack_red_zone_stop,
  output reg               o_stack_yellow_zone_flag_n,
  // result zero detect
  input  wire [15:0]       i_result,
  output reg               o_result_zero,
  output reg               o_result_low_zero,
  output reg               o_result_byte_zero,
  // scratch pad select and data
  input  wire              i_sel_imm,
  input  wire              i_sel_src,
  input  wire              i_sel_dst,
  input  wire              i_sel_ba,
  input  wire [3:0]        i_imm_reg,
  input  wire [8:0]        i_instr,
  input  wire              i_byte_op,
  input  wire              i_scratch_wr,
  input  wire              i_scratch_rd,
  input  wire [DATA_W-1:0] i_datapath_select_bus,
  output reg  [3:0]        o_scratch_sel_n,
  output reg               o_stack_or_pc_reg_sel,
  output reg               o_force_inc_two,
  output reg               o_stack_check_en,
  output reg  [DATA_W-1:0] o_read_bus,
  // console switches and microaddress match
  input  wire [17:0]       i_console_switch_word,
  input  wire              i_switch_to_bus_gate,
  input  wire [8:0]        i_next_microaddr_buf,
  input  wire              i_cycle_end,
  input  wire              i_cycle_class_two,
  input  wire              i_cycle_class_three,
  output reg  [15:0]       o_bus_data,
  output reg               o_bus_data_oe,
  output reg  [1:0]        o_upper_switch,
  output reg               o_microaddr_equal,
  output reg               o_match_trig_n,
  output reg               o_halt_req
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  reg rst_meta_n;
  reg rst_n;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  reg [1:0] ctrl;
  reg [7:0] limit;
  wire      limit_fitted = ctrl[`CTRL_LIMIT_FITTED];
  wire      halt_enable  = ctrl[`CTRL_HALT_ENABLE];

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl  <= `CTRL_RESET;
      limit <= `LIMIT_RESET;
    end else if (i_wr) begin
      case (i_addr)
        `REG_CTRL:  ctrl  <= i_wdata[1:0];
        `REG_LIMIT: limit <= i_wdata[7:0];
        default:    ctrl  <= ctrl;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal address decode
  wire ps_hit  = (i_bus_addr == `STATUS_WORD_ADDR);                  // RULE1
  wire slr_hit = limit_fitted && (i_bus_addr == `STACK_LIMIT_ADDR); // RULE3
  wire reg_hit = (i_bus_addr[15:4] == `SCRATCH_BASE_HI);             // RULE4
  wire sr_hit  = (i_bus_addr == `SWITCH_WORD_ADDR);

  // stack zones: yellow below limit page, red a fixed span further down
  wire [15:0] yellow_top = {limit, 8'h00};
  wire [15:0] red_top    = yellow_top - `RED_ZONE_BYTES;
  wire        in_yellow  = (i_bus_addr < yellow_top);
  wire        in_red     = (yellow_top >= `RED_ZONE_BYTES) && (i_bus_addr < red_top);

  ////////////////////////////////////////////////////////////////////////////
  // scratch pad selection
  reg  [3:0] reg_num;
  always @* begin
    // microword number wins if control ever sets more than one source
    if (i_sel_imm)
      reg_num = i_imm_reg;                                           // RULE13
    else if (i_sel_src)
      reg_num = {1'b0, i_instr[8:6]};                                // RULE13
    else if (i_sel_dst)
      reg_num = {1'b0, i_instr[2:0]};                                // RULE13
    else if (i_sel_ba)
      reg_num = i_bus_addr[3:0];                                     // RULE13
    else
      reg_num = 4'h0;
  end

  wire [3:0] sel_n    = ~reg_num;                                    // RULE17
  wire       x67      = (reg_num[2:1] == 2'b11);                     // RULE15
  wire       sel_any  = i_sel_imm | i_sel_src | i_sel_dst | i_sel_ba;
  // low select line high means even register; bit 3 low keeps 16 octal out
  wire       sp_sel   = x67 && sel_n[0] && !reg_num[3];              // RULE16

  reg [DATA_W-1:0] scratch [0:REG_COUNT-1];
  // latch storage in the original forces write-then-read; here a same-cycle read gets the old word
  always @(posedge i_mclk) begin
    if (i_scratch_wr && sel_any)
      scratch[reg_num] <= i_datapath_select_bus;                     // RULE14
  end

  ////////////////////////////////////////////////////////////////////////////
  // microaddress match
  wire match = (i_console_switch_word[8:0] == i_next_microaddr_buf); // RULE19 RULE23
  reg  prev_long;
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n)
      prev_long <= 1'b0;
    else if (i_cycle_end)
      prev_long <= i_cycle_class_two | i_cycle_class_three;          // RULE21
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal address hits and bus address bit tests
  reg              next_status_word_addr_hit;
  reg              next_status_load_en;
  reg              next_rebranch_req;
  reg              next_stack_limit_addr_hit;
  reg              next_scratch_addr_hit;
  reg              next_switch_word_addr_hit;
  reg              next_slave_sync_ack;
  reg              next_ba_mid_zero;
  reg              next_ba_upper_ones_n;
  reg              next_ba_high_ones_n;

  always @* begin
    next_status_word_addr_hit = ps_hit;                 // RULE1
    next_status_load_en       = ps_hit && i_bus_access; // RULE1
    // status writes may change priority, so pending requests are looked at again
    next_rebranch_req         = ps_hit && i_bus_access; // RULE2
    next_stack_limit_addr_hit = slr_hit;                // RULE3
    next_scratch_addr_hit     = reg_hit;                // RULE4
    next_switch_word_addr_hit = sr_hit;                 // RULE5
    // internal addresses answer the bus here; nothing outside sees them
    next_slave_sync_ack       = i_bus_access && (ps_hit || slr_hit || reg_hit || sr_hit); // RULE1 RULE3 RULE5
    next_ba_mid_zero          = (i_bus_addr[6:3] == 4'h0); // RULE6
    next_ba_upper_ones_n      = ~&i_bus_addr[7:5];         // RULE7
    // content test only, low for any access in the top page
    next_ba_high_ones_n       = ~&i_bus_addr[15:8];        // RULE8
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_status_word_addr_hit <= 1'b0;
      o_status_load_en       <= 1'b0;
      o_rebranch_req         <= 1'b0;
      o_stack_limit_addr_hit <= 1'b0;
      o_scratch_addr_hit     <= 1'b0;
      o_switch_word_addr_hit <= 1'b0;
      o_slave_sync_ack       <= 1'b0;
      o_ba_mid_zero          <= 1'b0;
      o_ba_upper_ones_n      <= 1'b1;
      o_ba_high_ones_n       <= 1'b1;
    end else begin
      o_status_word_addr_hit <= next_status_word_addr_hit;
      o_status_load_en       <= next_status_load_en;
      o_rebranch_req         <= next_rebranch_req;
      o_stack_limit_addr_hit <= next_stack_limit_addr_hit;
      o_scratch_addr_hit     <= next_scratch_addr_hit;
      o_switch_word_addr_hit <= next_switch_word_addr_hit;
      o_slave_sync_ack       <= next_slave_sync_ack;
      o_ba_mid_zero          <= next_ba_mid_zero;
      o_ba_upper_ones_n      <= next_ba_upper_ones_n;
      o_ba_high_ones_n       <= next_ba_high_ones_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack zone checks, armed by the stack pointer select of the cycle before
  reg              next_stack_red_zone_stop;
  reg              next_stack_yellow_zone_flag_n;

  always @* begin
    next_stack_red_zone_stop      = o_stack_check_en && i_stack_access && in_red; // RULE9
    // red wins so one reference never raises both stop and trap
    next_stack_yellow_zone_flag_n = ~(o_stack_check_en && i_stack_access && in_yellow && !in_red); // RULE10
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_stack_red_zone_stop      <= 1'b0;
      o_stack_yellow_zone_flag_n <= 1'b1;
    end else begin
      o_stack_red_zone_stop      <= next_stack_red_zone_stop;
      o_stack_yellow_zone_flag_n <= next_stack_yellow_zone_flag_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result zero detect; byte test reuses the low nibble term
  reg              next_result_zero;
  reg              next_result_low_zero;
  reg              next_result_byte_zero;

  always @* begin
    next_result_zero      = (i_result == 16'h0000);   // RULE11
    next_result_low_zero  = (i_result[3:0] == 4'h0);  // RULE12
    next_result_byte_zero = next_result_low_zero && (i_result[7:4] == 4'h0); // RULE12
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_result_zero      <= 1'b0;
      o_result_low_zero  <= 1'b0;
      o_result_byte_zero <= 1'b0;
    end else begin
      o_result_zero      <= next_result_zero;
      o_result_low_zero  <= next_result_low_zero;
      o_result_byte_zero <= next_result_byte_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scratch pad select outputs and read bus
  reg [3:0]        next_scratch_sel_n;
  reg              next_stack_or_pc_reg_sel;
  reg              next_force_inc_two;
  reg              next_stack_check_en;
  reg [DATA_W-1:0] next_read_bus;

  always @* begin
    next_scratch_sel_n       = sel_n;           // RULE17
    next_stack_or_pc_reg_sel = x67 && sel_any;  // RULE15
    // upper pair 16/17 octal holds scratch values, never a pointer
    next_force_inc_two       = x67 && sel_any && !reg_num[3] && i_byte_op; // RULE15
    next_stack_check_en      = sp_sel && sel_any; // RULE16
    // idle wired-OR bus reads as zero
    next_read_bus            = (i_scratch_rd && sel_any) ? scratch[reg_num] : {DATA_W{1'b0}}; // RULE14
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_scratch_sel_n       <= 4'hf;
      o_stack_or_pc_reg_sel <= 1'b0;
      o_force_inc_two       <= 1'b0;
      o_stack_check_en      <= 1'b0;
      o_read_bus            <= {DATA_W{1'b0}};
    end else begin
      o_scratch_sel_n       <= next_scratch_sel_n;
      o_stack_or_pc_reg_sel <= next_stack_or_pc_reg_sel;
      o_force_inc_two       <= next_force_inc_two;
      o_stack_check_en      <= next_stack_check_en;
      o_read_bus            <= next_read_bus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // console switch outputs, match level, trigger and halt
  reg [15:0]       next_bus_data;
  reg              next_bus_data_oe;
  reg [1:0]        next_upper_switch;
  reg              next_microaddr_equal;
  reg              next_match_trig_n;
  reg              next_halt_req;

  always @* begin
    // data held at zero while not gated, so the enable alone decides
    next_bus_data        = i_switch_to_bus_gate ? i_console_switch_word[15:0] : 16'h0000; // RULE18
    next_bus_data_oe     = i_switch_to_bus_gate;         // RULE18
    next_upper_switch    = i_console_switch_word[17:16]; // RULE22
    next_microaddr_equal = match;                        // RULE19
    // trigger fires on every match at a cycle end, halted or not
    next_match_trig_n    = ~(i_cycle_end && match);      // RULE20
    // a target two words after a short word cannot be stopped on
    next_halt_req        = i_cycle_end && match && halt_enable && prev_long; // RULE21
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_data        <= 16'h0000;
      o_bus_data_oe     <= 1'b0;
      o_upper_switch    <= 2'h0;
      o_microaddr_equal <= 1'b0;
      o_match_trig_n    <= 1'b1;
      o_halt_req        <= 1'b0;
    end else begin
      o_bus_data        <= next_bus_data;
      o_bus_data_oe     <= next_bus_data_oe;
      o_upper_switch    <= next_upper_switch;
      o_microaddr_equal <= next_microaddr_equal;
      o_match_trig_n    <= next_match_trig_n;
      o_halt_req        <= next_halt_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after strobe
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd) begin
      case (i_addr)
        `REG_CTRL:   o_rdata <= {30'h0, ctrl};
        `REG_LIMIT:  o_rdata <= {24'h0, limit};
        `REG_STATUS: o_rdata <= {26'h0, prev_long, o_microaddr_equal, o_stack_check_en,
                                 !o_stack_yellow_zone_flag_n, o_stack_red_zone_stop, o_result_zero};
        default:     o_rdata <= 32'h0000_0000;
      endcase
    end else
      o_rdata <= 32'h0000_0000;
  end

endmodule // addr_decode_core

// ===== test/addr_decode_assertions.sv
// concurrent checks on decode, scratch select and microaddress match outputs
`timescale 1ns/10ps
`include "addr_decode_defs.vh"
module addr_decode_checker (
  // clock, reset and watched inputs
  input wire        i_mclk, i_rst_n, i_bus_access, i_stack_access, i_sel_imm, i_switch_to_bus_gate, i_cycle_end,
  input wire [15:0] i_bus_addr, i_result,
  input wire [3:0]  i_imm_reg,
  input wire [17:0] i_console_switch_word,
  input wire [8:0]  i_next_microaddr_buf,
  input wire        i_byte_op,
  // watched outputs
  input wire        o_status_word_addr_hit, o_rebranch_req, o_stack_limit_addr_hit, o_scratch_addr_hit,
  input wire        o_switch_word_addr_hit, o_slave_sync_ack, o_ba_mid_zero, o_ba_upper_ones_n, o_ba_high_ones_n,
  input wire        o_stack_red_zone_stop, o_stack_yellow_zone_flag_n, o_result_zero, o_result_low_zero,
  input wire        o_result_byte_zero, o_stack_or_pc_reg_sel, o_stack_check_en, o_bus_data_oe,
  input wire        o_microaddr_equal, o_match_trig_n, o_halt_req, o_status_load_en, o_force_inc_two,
  input wire [3:0]  o_scratch_sel_n,
  input wire [15:0] o_bus_data,
  input wire [1:0]  o_upper_switch
);
  reg [2:0] up;
  // outputs lag the raw reset by three edges, two of them in the synchroniser; one spare edge since disable reads current values
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) up <= 3'h0;
    else if (up != 3'h4) up <= up + 3'h1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (up != 3'h4);
  status_hit_a: assert property (o_status_word_addr_hit == ($past(i_bus_addr) == `STATUS_WORD_ADDR))
    else $error("status word hit wrong");
  rebranch_req_a: assert property ({o_rebranch_req, o_status_load_en} ==
    {2{$past(i_bus_access) && o_status_word_addr_hit}}) else $error("rebranch request wrong");
  force_inc_a: assert property (o_force_inc_two == ($past(i_byte_op) && o_stack_or_pc_reg_sel
    && o_scratch_sel_n[3])) else $error("increment by two wrong");
  sync_ack_a: assert property (o_slave_sync_ack == ($past(i_bus_access) && (o_status_word_addr_hit
    || o_stack_limit_addr_hit || o_scratch_addr_hit || o_switch_word_addr_hit))) else $error("slave sync wrong");
  addr_hits_a: assert property ({o_scratch_addr_hit, o_switch_word_addr_hit} == {$past(i_bus_addr[15:4])
    == `SCRATCH_BASE_HI, $past(i_bus_addr) == `SWITCH_WORD_ADDR}) else $error("scratch or switch hit wrong");
  addr_bits_a: assert property ({o_ba_mid_zero, o_ba_upper_ones_n, o_ba_high_ones_n} == {$past(i_bus_addr[6:3])
    == 4'h0, $past(i_bus_addr[7:5]) != 3'h7, $past(i_bus_addr[15:8]) != 8'hff}) else $error("address bit tests wrong");
  stack_zone_a: assert property ((o_stack_red_zone_stop || !o_stack_yellow_zone_flag_n) |-> $past(i_stack_access)
    && $past(o_stack_check_en) && o_stack_yellow_zone_flag_n == o_stack_red_zone_stop) else $error("stack zone wrong");
  result_zero_a: assert property ({o_result_zero, o_result_low_zero, o_result_byte_zero} == {$past(i_result)
    == 16'h0, $past(i_result[3:0]) == 4'h0, $past(i_result[7:0]) == 8'h0}) else $error("zero detect wrong");
  sel_cmpl_a: assert property ($past(i_sel_imm) |-> o_scratch_sel_n == ~$past(i_imm_reg))
    else $error("scratch select wrong");
  stack_sel_a: assert property (o_stack_check_en == (o_stack_or_pc_reg_sel && o_scratch_sel_n[3] && o_scratch_sel_n[0])
    && (!o_stack_or_pc_reg_sel || o_scratch_sel_n[2:1] == 2'h0)) else $error("stack register detect wrong");
  switch_out_a: assert property (o_bus_data_oe == $past(i_switch_to_bus_gate) && o_upper_switch
    == $past(i_console_switch_word[17:16]) && o_bus_data == ($past(i_switch_to_bus_gate) ?
    $past(i_console_switch_word[15:0]) : 16'h0)) else $error("switch outputs wrong");
  addr_match_a: assert property (o_microaddr_equal == ($past(i_console_switch_word[8:0]) == $past(i_next_microaddr_buf)))
    else $error("microaddress match wrong");
  trig_pulse_a: assert property (!o_match_trig_n == ($past(i_cycle_end) && $past(i_console_switch_word[8:0])
    == $past(i_next_microaddr_buf))) else $error("match trigger wrong");
  halt_pulse_a: assert property (o_halt_req |-> !o_match_trig_n ##1 !o_halt_req)
    else $error("halt request wrong");
endmodule  // addr_decode_checker
bind addr_decode_core addr_decode_checker u_chk (.*);

// ===== test/seq_partner.sv
// microprogram sequencer model: next microaddress, cycle end pulse and cycle class
`timescale 1ns/10ps
module seq_partner (
  input  wire       i_mclk,
  input  wire       i_rst_n,
  output reg  [8:0] o_upc,
  output reg        o_cycle_end,
  output reg        o_class_two,
  output reg        o_class_three
);
  reg [1:0] ph;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph <= 2'h0;
      o_upc <= 9'h000;
      o_cycle_end <= 1'b0;
      o_class_two <= 1'b0;
      o_class_three <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      o_cycle_end <= (ph == 2'h3);
      // address moves only at a cycle end, already branched
      if (ph == 2'h3) o_upc <= o_upc + 9'h001;
      // class of the word now ending; words at x00 are short
      o_class_two <= (ph == 2'h3) && o_upc[0];
      o_class_three <= (ph == 2'h3) && (o_upc[1:0] == 2'h2);
    end
  end
endmodule  // seq_partner

// ===== test/tb_top.sv
// self-checking bench for the address decode and scratch pad select block
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_top;
  reg         i_mclk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_bus_access = 0, i_stack_access = 0, i_sel_imm = 0;
  reg         i_sel_src = 0, i_sel_dst = 0, i_sel_ba = 0, i_byte_op = 0, i_scratch_wr = 0, i_scratch_rd = 0;
  reg         i_switch_to_bus_gate = 0, rp = 0, sp = 0;
  reg  [7:0]  i_addr = 0;
  reg  [31:0] i_wdata = 0;
  reg  [15:0] i_bus_addr = 0, i_result = 0, i_datapath_select_bus = 0, lfsr = 16'h0049;
  reg  [3:0]  i_imm_reg = 0;
  reg  [8:0]  i_instr = 0;
  reg  [17:0] i_console_switch_word = 0;
  wire        i_cycle_end, i_cycle_class_two, i_cycle_class_three, o_status_word_addr_hit, o_status_load_en;
  wire        o_rebranch_req, o_stack_limit_addr_hit, o_scratch_addr_hit, o_switch_word_addr_hit, o_slave_sync_ack;
  wire        o_ba_mid_zero, o_ba_upper_ones_n, o_ba_high_ones_n, o_stack_red_zone_stop, o_stack_yellow_zone_flag_n;
  wire        o_result_zero, o_result_low_zero, o_result_byte_zero, o_stack_or_pc_reg_sel, o_force_inc_two;
  wire        o_stack_check_en, o_bus_data_oe, o_microaddr_equal, o_match_trig_n, o_halt_req;
  wire [8:0]  i_next_microaddr_buf;
  wire [31:0] o_rdata;
  wire [15:0] o_read_bus, o_bus_data;
  wire [3:0]  o_scratch_sel_n;
  wire [1:0]  o_upper_switch;
  int         err_count = 0, check_count = 0, cyc = 0, i;
  logic [31:0] q[$], exp_v;
  logic [15:0] ta[6] = '{16'hfffe, 16'hfffc, 16'hff78, 16'hffc5, 16'hffd0, 16'h1234};
  logic [3:0]  rn[4] = '{4'h6, 4'h7, 4'he, 4'hf};
  addr_decode_core u_dut (.*);
  seq_partner u_seq (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_upc(i_next_microaddr_buf), .o_cycle_end(i_cycle_end),
    .o_class_two(i_cycle_class_two), .o_class_three(i_cycle_class_three));
  always #20 i_mclk = ~i_mclk;
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // every task starts just after a rising edge and leaves its strobes for the next call
  task bus(input w, input r, input [7:0] a, input [31:0] d, input [31:0] e);
    i_wr <= w; i_rd <= r; i_addr <= a; i_wdata <= d;
    if (r) q.push_back(e);
    @(posedge i_mclk);
  endtask
  task sp_op(input [3:0] s, input w, input r, input [15:0] d, input [31:0] e);
    {i_sel_imm, i_sel_src, i_sel_dst, i_sel_ba} <= s; i_scratch_wr <= w; i_scratch_rd <= r; i_datapath_select_bus <= d;
    if (r) q.push_back(e);
    @(posedge i_mclk);
  endtask
  task look(input [15:0] a, input e, input r, input y);
    i_bus_addr <= a; i_bus_access <= 1; i_stack_access <= 1;
    @(posedge i_mclk); @(negedge i_mclk);
    `CHK(o_slave_sync_ack, e)
    `CHK({o_stack_red_zone_stop, o_stack_yellow_zone_flag_n}, {r, y})
    @(posedge i_mclk);
  endtask
  always @(posedge i_mclk) begin
    rp <= i_rd; sp <= i_scratch_rd; cyc++;
    if (cyc == 20000) begin err_count++; finish_test; end
  end
  always @(negedge i_mclk) begin
    // pop once, the macro names its expected value twice
    if (rp) begin exp_v = q.pop_front(); `CHK(o_rdata, exp_v) end
    else if (sp) begin exp_v = q.pop_front(); `CHK({16'h0, o_read_bus}, exp_v) end
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    bus(1, 0, 8'h00, 32'hffffffff, 0); bus(1, 0, 8'h04, 32'h180, 0); bus(0, 1, 8'h00, 0, 32'h3);
    bus(0, 1, 8'h04, 0, 32'h80); bus(1, 0, 8'h0c, 32'h5, 0); bus(0, 1, 8'h0c, 0, 0); bus(0, 0, 0, 0, 0);
    $display("register port done");
    for (i = 0; i < 6; i++) look(ta[i], i < 4, 0, 1);
    bus(1, 0, 8'h00, 32'h2, 0); bus(0, 0, 0, 0, 0); look(16'hfffc, 0, 0, 1); bus(1, 0, 8'h00, 32'h1, 0);
    bus(0, 0, 0, 0, 0);
    repeat (300) begin
      lfsr = nxt(lfsr);
      i_bus_addr <= lfsr; i_bus_access <= lfsr[3]; i_switch_to_bus_gate <= lfsr[2];
      i_result <= lfsr[0] ? 16'h0 : lfsr & (lfsr[1] ? 16'hff00 : 16'hfff0); i_console_switch_word <= {lfsr[1:0], lfsr};
      @(posedge i_mclk);
    end
    $display("decode done");
    // each source feeds the same register file, so cross-source reads prove the select
    i_imm_reg <= 5; i_instr <= 9'o503; sp_op(8, 1, 0, 16'ha5a5, 0); sp_op(4, 0, 1, 0, 32'ha5a5);
    sp_op(2, 1, 0, 16'h3c3c, 0); i_bus_addr <= 16'hffc3; sp_op(1, 0, 1, 0, 32'h3c3c);
    for (i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      i_imm_reg <= i[3:0]; sp_op(8, 1, 0, lfsr, 0); sp_op(8, 0, 1, 0, {16'h0, lfsr});
    end
    i_byte_op <= 1;
    for (i = 0; i < 4; i++) begin
      i_imm_reg <= rn[i]; sp_op(8, 0, 0, 0, 0); @(negedge i_mclk);
      `CHK({o_force_inc_two, o_stack_or_pc_reg_sel, o_stack_check_en}, {i < 2, 1'b1, i == 0})
      `CHK(o_scratch_sel_n, ~rn[i])
      @(posedge i_mclk);
    end
    $display("scratch select done");
    i_imm_reg <= 6; sp_op(8, 0, 0, 0, 0);
    look(16'h7f00, 0, 1, 1); look(16'h7ff0, 0, 0, 0); look(16'h8000, 0, 0, 1);
    i_imm_reg <= 7; sp_op(8, 0, 0, 0, 0); look(16'h7f00, 0, 0, 1);
    $display("stack zone done");
    bus(1, 0, 8'h00, 32'h3, 0); bus(0, 0, 0, 0, 0);
    // 08 comes two words after a long word, 0a two after a short one, 0b runs with halting switched off
    for (i = 0; i < 3; i++) begin
      i_console_switch_word <= (i == 0) ? 18'h00008 : (i == 1) ? 18'h0000a : 18'h0000b; @(posedge i_mclk);
      repeat (2200) if (o_match_trig_n !== 1'b0) @(negedge i_mclk);
      `CHK({o_match_trig_n, o_halt_req}, {1'b0, i == 0})
      @(posedge i_mclk); bus(1, 0, 8'h00, (i > 0) ? 32'h1 : 32'h3, 0); bus(0, 0, 0, 0, 0);
    end
    $display("microaddress match done");
    finish_test;
  end
endmodule  // tb_top
